// file: design/sram_host_pkg.sv
// shared constants for the asynchronous static ram host controller
package sram_host_pkg;

  // ---------------------------------------------------------------
  // memory geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;

  // ---------------------------------------------------------------
  // timing, in nanoseconds and in ref_clk cycles
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int T_WE_PULSE_NS    = 35;
  localparam int T_READ_ACCESS_NS = 45;
  localparam int T_HIGH_Z_NS      = 18;
  // least times round up, none below one cycle
  localparam int WE_PULSE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC     = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_Z_CYC   = (T_HIGH_Z_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W      = 4;

  // ---------------------------------------------------------------
  // register map of the controller, byte addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_ADDR   = 5'h00;
  localparam logic [4:0] OFS_WDATA  = 5'h04;
  localparam logic [4:0] OFS_CTRL   = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_RDATA  = 5'h10;

  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_LOWER_BIT = 2;
  localparam int CTRL_UPPER_BIT = 3;
  localparam int CTRL_OEOFF_BIT = 4;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT  = 2;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_ACTIVE = 3'h3,
    ST_FINISH = 3'h2,
    ST_RECOV  = 3'h6
  } seq_state_t;

endpackage : sram_host_pkg

// file: design/phase_timer.sv
// down counter that times one phase of a memory access
`timescale 1ns/1ps
module phase_timer (
  input  wire logic                                ref_clk,
  input  wire logic                                sys_rst,
  input  wire logic                                load,
  input  wire logic [sram_host_pkg::TIMER_W-1:0]  count,
  output logic                                     expired
);

  logic [sram_host_pkg::TIMER_W-1:0] count_reg;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= 4'h0;
    end else if (load) begin
      count_reg <= count;
    end else if (count_reg != 4'h0) begin
      count_reg <= count_reg - 4'h1;
    end
  end

  // last cycle of the phase; a fresh load masks a stale expiry
  assign expired = (count_reg == 4'h1) && !load;

endmodule : phase_timer

// file: design/sram_host_ctrl.sv
// host controller driving an asynchronous 512k x 16 static ram, axi4-lite command side
//
// Overview of operation
// - write starts only with all qualifiers active; any one inactive ends it.
// - data setup and hold are referred to the edge that ends the write.
// - host never drives data while the ram may drive its pins.
// - lane enables must not toggle while deselected by chip selects.
// - strobe stays high throughout every read.
// - address valid before or together with selects and lanes going active.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module sram_host_ctrl (
  input  wire logic                               ref_clk,
  input  wire logic                               sys_rst,
  // axi4-lite slave
  input  wire logic [31:0]                        s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [31:0]                        s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  // memory pins
  output logic [sram_host_pkg::ADDR_W-1:0]        mem_addr,
  output logic                                    chip_sel_n,
  output logic                                    chip_sel,
  output logic                                    write_n,
  output logic                                    out_en_n,
  output logic                                    upper_lane_n,
  output logic                                    lower_lane_n,
  input  wire logic [sram_host_pkg::DATA_W-1:0]   data_in,
  output logic [sram_host_pkg::DATA_W-1:0]        data_out,
  output logic                                    data_oe
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sram_host_pkg::seq_state_t              state_reg;
  logic [sram_host_pkg::ADDR_W-1:0]       cmd_addr_reg;
  logic [sram_host_pkg::DATA_W-1:0]       cmd_wdata_reg;
  logic [sram_host_pkg::DATA_W-1:0]       rd_data_reg;
  logic                                   cmd_write_reg;
  logic                                   cmd_lower_reg;
  logic                                   cmd_upper_reg;
  logic                                   cmd_oeoff_reg;
  logic                                   done_reg;
  logic                                   err_reg;
  logic                                   aw_got_reg;
  logic                                   w_got_reg;
  logic [4:0]                             aw_ofs_reg;
  logic [31:0]                            w_data_reg;
  logic [3:0]                             w_strb_reg;
  logic                                   bus_wr;
  logic                                   start_req;
  logic                                   start_ok;
  logic                                   clear_done;
  logic                                   clear_err;
  logic                                   finish_now;
  logic                                   timer_load;
  logic [sram_host_pkg::TIMER_W-1:0]      timer_count;
  logic                                   timer_expired;
  logic                                   busy;
  logic [31:0]                            rd_word;
  logic                                   rd_hit;

  assign busy = (state_reg != sram_host_pkg::ST_IDLE);

  // ---------------------------------------------------------------
  // axi4-lite write channels
  // ---------------------------------------------------------------
  // address and data are taken in either order; the write acts once both are held
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      aw_got_reg    <= 1'b0;
      aw_ofs_reg    <= 5'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_reg    <= 1'b1;
      aw_ofs_reg    <= s_axi_awaddr[4:0];
    end else if (bus_wr) begin
      aw_got_reg    <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !aw_got_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_wready <= 1'b0;
      w_got_reg    <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_reg    <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
    end else if (bus_wr) begin
      w_got_reg    <= 1'b0;
    end else begin
      s_axi_wready <= s_axi_wvalid && !w_got_reg && !s_axi_bvalid;
    end
  end

  assign bus_wr = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sram_host_pkg::RESP_OKAY;
    end else if (bus_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_ofs_reg[1:0] != 2'h0 || aw_ofs_reg > sram_host_pkg::OFS_STATUS) ?
                      sram_host_pkg::RESP_SLVERR : sram_host_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // command registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_addr_reg  <= sram_host_pkg::ADDR_RST;
      cmd_wdata_reg <= sram_host_pkg::DATA_RST;
    end else if (bus_wr && !busy) begin
      // address and data are frozen while an access runs
      if (aw_ofs_reg == sram_host_pkg::OFS_ADDR) begin
        if (w_strb_reg[0]) cmd_addr_reg[7:0]   <= w_data_reg[7:0];
        if (w_strb_reg[1]) cmd_addr_reg[15:8]  <= w_data_reg[15:8];
        if (w_strb_reg[2]) cmd_addr_reg[18:16] <= w_data_reg[18:16];
      end
      if (aw_ofs_reg == sram_host_pkg::OFS_WDATA) begin
        if (w_strb_reg[0]) cmd_wdata_reg[7:0]  <= w_data_reg[7:0];
        if (w_strb_reg[1]) cmd_wdata_reg[15:8] <= w_data_reg[15:8];
      end
    end
  end

  assign start_req = bus_wr && aw_ofs_reg == sram_host_pkg::OFS_CTRL && w_strb_reg[0]
                     && w_data_reg[sram_host_pkg::CTRL_START_BIT];
  // a command with no lane enabled would only deselect the ram, so it is refused
  assign start_ok  = start_req && !busy && (w_data_reg[sram_host_pkg::CTRL_LOWER_BIT]
                     || w_data_reg[sram_host_pkg::CTRL_UPPER_BIT]);
  assign clear_done = bus_wr && aw_ofs_reg == sram_host_pkg::OFS_STATUS && w_strb_reg[0]
                      && w_data_reg[sram_host_pkg::STAT_DONE_BIT];
  assign clear_err  = bus_wr && aw_ofs_reg == sram_host_pkg::OFS_STATUS && w_strb_reg[0]
                      && w_data_reg[sram_host_pkg::STAT_ERR_BIT];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_write_reg <= 1'b0;
      cmd_lower_reg <= 1'b0;
      cmd_upper_reg <= 1'b0;
      cmd_oeoff_reg <= 1'b0;
    end else if (start_ok) begin
      cmd_write_reg <= w_data_reg[sram_host_pkg::CTRL_WRITE_BIT];
      cmd_lower_reg <= w_data_reg[sram_host_pkg::CTRL_LOWER_BIT];
      cmd_upper_reg <= w_data_reg[sram_host_pkg::CTRL_UPPER_BIT];
      cmd_oeoff_reg <= w_data_reg[sram_host_pkg::CTRL_OEOFF_BIT];
    end
  end

  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      done_reg <= finish_now || (done_reg && !clear_done);
      err_reg  <= (start_req && !start_ok) || (err_reg && !clear_err);
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    unique case (s_axi_araddr[4:0])
      sram_host_pkg::OFS_ADDR:   rd_word[18:0] = cmd_addr_reg;
      sram_host_pkg::OFS_WDATA:  rd_word[15:0] = cmd_wdata_reg;
      sram_host_pkg::OFS_CTRL:   rd_word[4:1]  = {cmd_oeoff_reg, cmd_upper_reg, cmd_lower_reg, cmd_write_reg};
      sram_host_pkg::OFS_STATUS: rd_word[2:0]  = {err_reg, done_reg, busy};
      sram_host_pkg::OFS_RDATA:  rd_word[15:0] = rd_data_reg;
      default:                   rd_hit        = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= sram_host_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? sram_host_pkg::RESP_OKAY : sram_host_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid;
    end
  end

  // ---------------------------------------------------------------
  // access sequencer and pins
  // ---------------------------------------------------------------
  phase_timer u_timer (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .load    (timer_load),
    .count   (timer_count),
    .expired (timer_expired)
  );

  assign timer_load  = (state_reg == sram_host_pkg::ST_SETUP)
                       || (state_reg == sram_host_pkg::ST_FINISH);
  assign timer_count = (state_reg == sram_host_pkg::ST_FINISH) ? 4'(sram_host_pkg::HIGH_Z_CYC) :
                       cmd_write_reg ? 4'(sram_host_pkg::WE_PULSE_CYC) : 4'(sram_host_pkg::READ_CYC);
  assign finish_now  = (state_reg == sram_host_pkg::ST_RECOV) && timer_expired;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= sram_host_pkg::ST_IDLE;
      mem_addr     <= sram_host_pkg::ADDR_RST;
      chip_sel_n   <= 1'b1;
      chip_sel     <= 1'b0;
      write_n      <= 1'b1;
      out_en_n     <= 1'b1;
      upper_lane_n <= 1'b1;
      lower_lane_n <= 1'b1;
      data_out     <= sram_host_pkg::DATA_RST;
      data_oe      <= 1'b0;
    end else begin
      unique case (state_reg)
        sram_host_pkg::ST_IDLE: if (start_ok) begin
          mem_addr  <= cmd_addr_reg;
          state_reg <= sram_host_pkg::ST_SETUP;
        end
        sram_host_pkg::ST_SETUP: begin
          // selects and lanes move together, never lanes alone while deselected
          chip_sel_n   <= 1'b0;
          chip_sel     <= 1'b1;
          upper_lane_n <= !cmd_upper_reg;
          lower_lane_n <= !cmd_lower_reg;
          // write data goes out with output enable high, so the ram cannot fight it
          data_out     <= cmd_wdata_reg;
          data_oe      <= cmd_write_reg;
          write_n      <= !cmd_write_reg;
          out_en_n     <= cmd_write_reg || cmd_oeoff_reg;
          state_reg    <= sram_host_pkg::ST_ACTIVE;
        end
        sram_host_pkg::ST_ACTIVE: if (timer_expired) begin
          // the strobe ends the write; data held one cycle past that edge
          write_n   <= 1'b1;
          out_en_n  <= 1'b1;
          state_reg <= sram_host_pkg::ST_FINISH;
        end
        sram_host_pkg::ST_FINISH: begin
          // both selects drop together with the strobe already high
          chip_sel_n   <= 1'b1;
          chip_sel     <= 1'b0;
          upper_lane_n <= 1'b1;
          lower_lane_n <= 1'b1;
          data_oe      <= 1'b0;
          state_reg    <= sram_host_pkg::ST_RECOV;
        end
        sram_host_pkg::ST_RECOV: if (timer_expired) begin
          state_reg <= sram_host_pkg::ST_IDLE;
        end
        default: state_reg <= sram_host_pkg::ST_IDLE;
      endcase
    end
  end

  // read data taken at the edge that closes the output-enable phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg <= sram_host_pkg::DATA_RST;
    end else if (state_reg == sram_host_pkg::ST_ACTIVE && timer_expired && !out_en_n) begin
      // floating lanes read back as zero
      rd_data_reg <= {upper_lane_n ? 8'h00 : data_in[15:8], lower_lane_n ? 8'h00 : data_in[7:0]};
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_write_qualified: assert property (!write_n |-> !chip_sel_n && chip_sel && !(upper_lane_n && lower_lane_n))
    else $error("write strobe low without all qualifiers active");
  chk_data_hold_end: assert property ($rose(write_n) |-> data_oe && $stable(data_out))
    else $error("write data not held at the strobe rising edge");
  chk_no_bus_fight: assert property (data_oe |-> out_en_n)
    else $error("host drives data while ram output is enabled");
  chk_lanes_quiet: assert property (chip_sel_n && $past(chip_sel_n) |-> upper_lane_n && lower_lane_n)
    else $error("lane enable active while deselected");
  chk_read_strobe_high: assert property (!out_en_n |-> write_n)
    else $error("strobe low during read");
  chk_addr_stable: assert property (!chip_sel_n |-> $stable(mem_addr))
    else $error("address changed while selected");
  chk_selects_together: assert property ($rose(chip_sel_n) |-> $fell(chip_sel) && write_n && $past(write_n))
    else $error("selects not released together with strobe high");
  chk_write_pulse_len: assert property ($fell(write_n) |-> !write_n ##1 write_n)
    else $error("write pulse length wrong");
  chk_access_bounded: assert property (start_ok |-> ##[4:8] !busy)
    else $error("access did not complete in time");
  chk_data_release: assert property ($fell(data_oe) |-> chip_sel_n && write_n)
    else $error("data released before write closed");

  cov_full_write: cover property (start_ok && w_data_reg[1] && w_data_reg[2] && w_data_reg[3]);
  cov_lower_read: cover property ($fell(out_en_n) && !lower_lane_n && upper_lane_n);
  cov_refused: cover property (start_req && !start_ok);
  cov_done_clear_race: cover property (finish_now && clear_done);

endmodule : sram_host_ctrl

// file: verif/sram_model.sv
// behavioural model of the 512k x 16 static ram seen at the controller's pins
`timescale 1ns/1ps
module sram_model (
  input  wire logic [18:0] mem_addr,
  input  wire logic        chip_sel_n,
  input  wire logic        chip_sel,
  input  wire logic        write_n,
  input  wire logic        out_en_n,
  input  wire logic        upper_lane_n,
  input  wire logic        lower_lane_n,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  output logic      [15:0] data_in,
  output logic             fault
);
  logic [15:0] mem [int];
  logic [15:0] w;
  logic        sel;
  logic        rd_en;
  initial fault = 1'b0;
  // ---------------------------------------------------------------
  // pin decode
  // ---------------------------------------------------------------
  // no clock: decode again on every pin change
  always @(mem_addr or chip_sel_n or chip_sel or write_n or out_en_n or upper_lane_n or lower_lane_n
           or data_out or data_oe) begin
    sel   = !chip_sel_n && chip_sel && !(upper_lane_n && lower_lane_n);
    rd_en = sel && write_n && !out_en_n;
    w     = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
    // level write: the value present when a qualifier drops is what stays
    if (sel && !write_n) begin
      if (!lower_lane_n) w[7:0] = data_out[7:0];
      if (!upper_lane_n) w[15:8] = data_out[15:8];
      mem[mem_addr] = w;
    end
    // released bytes show the inverse, so a floating lane never looks like data
    data_in[7:0]  = data_oe ? data_out[7:0] : (rd_en && !lower_lane_n) ? w[7:0] : ~w[7:0];
    data_in[15:8] = data_oe ? data_out[15:8] : (rd_en && !upper_lane_n) ? w[15:8] : ~w[15:8];
    if (data_oe && rd_en) fault = 1'b1;
  end
endmodule : sram_model

// file: verif/test_sram_host_ctrl.sv
// self-checking bench for the static ram host controller
`timescale 1ns/1ps
module test_sram_host_ctrl;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rdat;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        chip_sel_n, chip_sel, write_n, out_en_n, upper_lane_n, lower_lane_n, data_oe, fault;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, ln;
  logic [18:0] mem_addr, a;
  logic [15:0] data_in, data_out, d;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0;
  int          ref_mem [int];
  integer      seed = 32'hA42D;

  always #50 ref_clk = ~ref_clk;

  sram_host_ctrl sram_host_ctrl_inst (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mem_addr, .chip_sel_n, .chip_sel, .write_n, .out_en_n, .upper_lane_n, .lower_lane_n, .data_in,
    .data_out, .data_oe);
  sram_model sram_model_inst (.mem_addr, .chip_sel_n, .chip_sel, .write_n, .out_en_n, .upper_lane_n,
    .lower_lane_n, .data_out, .data_oe, .data_in, .fault);

  // ---------------------------------------------------------------
  // comparison and closing
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // pin watch, half a cycle away from the launching edge
  always @(negedge ref_clk) begin
    if (!sys_rst && write_n === 1'b0)
      check("write qualifiers", {chip_sel_n, chip_sel, data_oe, upper_lane_n & lower_lane_n}, 4'h6);
    if (!sys_rst && out_en_n === 1'b0)
      check("strobe in read", write_n, 1'b1);
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [31:0] ad, input logic [31:0] dt);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk);
      aw_done = aw_done || s_axi_awready === 1'b1;
      w_done  = w_done || s_axi_wready === 1'b1;
      s_axi_awvalid <= !aw_done;
      s_axi_wvalid  <= !w_done;
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] ad);
    @(posedge ref_clk);
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  function automatic logic [15:0] exp_rd(input logic [18:0] ma, input logic [1:0] lanes);
    logic [15:0] w;
    w = ref_mem.exists(ma) ? 16'(ref_mem[ma]) : 16'h0000;
    return {lanes[1] ? w[15:8] : 8'h00, lanes[0] ? w[7:0] : 8'h00};
  endfunction : exp_rd

  // one memory access through the command registers, waited on through done
  task automatic mem_op(input logic [18:0] ma, input logic [15:0] md, input logic wr, input logic [1:0] lanes,
                        input logic oeoff);
    logic [15:0] old;
    old = exp_rd(ma, 2'h3);
    axi_wr({27'h0, sram_host_pkg::OFS_ADDR}, {13'h0, ma});
    axi_wr({27'h0, sram_host_pkg::OFS_WDATA}, {16'h0, md});
    axi_wr({27'h0, sram_host_pkg::OFS_CTRL}, {27'h0, oeoff, lanes, wr, 1'b1});
    check("start resp", resp, sram_host_pkg::RESP_OKAY);
    do axi_rd({27'h0, sram_host_pkg::OFS_STATUS}); while (rdat[1] !== 1'b1);
    check("status done", rdat, 32'h2);
    axi_wr({27'h0, sram_host_pkg::OFS_STATUS}, 32'h6);
    if (wr) ref_mem[ma] = {16'h0, lanes[1] ? md[15:8] : old[15:8], lanes[0] ? md[7:0] : old[7:0]};
  endtask : mem_op

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    // raised as an event at time zero so the design's pins are reset before the first sampling edge
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    check("idle pins", {chip_sel_n, chip_sel, write_n, out_en_n, upper_lane_n, lower_lane_n, data_oe}, 7'h5E);
    for (int i = 0; i < 9; i++) begin
      a  = 19'($random(seed));
      d  = 16'($random(seed));
      ln = 2'(i % 3 + 1);
      mem_op(a, 16'($random(seed)), 1'b1, 2'h3, 1'b0);
      mem_op(a, d, 1'b1, ln, 1'b0);
      mem_op(a, 16'h0000, 1'b0, ln, 1'b0);
      axi_rd({27'h0, sram_host_pkg::OFS_RDATA});
      check("lane read", rdat, {16'h0, exp_rd(a, ln)});
      mem_op(a, 16'h0000, 1'b0, 2'h3, 1'b0);
      axi_rd({27'h0, sram_host_pkg::OFS_RDATA});
      check("word read", rdat, {16'h0, exp_rd(a, 2'h3)});
      // output disabled: nothing new may be captured
      mem_op(a ^ 19'h1, 16'h0000, 1'b0, ln, 1'b1);
      axi_rd({27'h0, sram_host_pkg::OFS_RDATA});
      check("oe off read", rdat, {16'h0, exp_rd(a, 2'h3)});
    end
    axi_wr({27'h0, sram_host_pkg::OFS_CTRL}, 32'h1);
    axi_rd({27'h0, sram_host_pkg::OFS_STATUS});
    check("laneless start", rdat, 32'h4);
    for (int k = 0; k < 2; k++) begin
      axi_wr(k ? 32'h2 : 32'h14, 32'hFFFF);
      check("bad write resp", resp, sram_host_pkg::RESP_SLVERR);
    end
    axi_rd({27'h0, sram_host_pkg::OFS_ADDR});
    check("addr kept", rdat, {13'h0, a ^ 19'h1});
    // only the middle byte lane is strobed: the other address bits must stay
    s_axi_wstrb <= 4'h2;
    axi_wr({27'h0, sram_host_pkg::OFS_ADDR}, 32'h00075A00);
    s_axi_wstrb <= 4'hF;
    axi_rd({27'h0, sram_host_pkg::OFS_ADDR});
    check("addr byte write", rdat, {13'h0, a[18:16], 8'h5A, a[7:1], ~a[0]});
    axi_rd(32'h18);
    check("bad read resp", resp, sram_host_pkg::RESP_SLVERR);
    check("bad read data", rdat, 32'h0);
    check("bus contention", fault, 1'b0);
    complete_run();
  end
endmodule : test_sram_host_ctrl
